/* File: src/boot_self_test_led_sequencer.v */
`timescale 1ns/1ps
`include "boot_seq_consts.vh"
module boot_self_test_led_sequencer #(
  parameter LAMP_TEST_CYCLES = (`CLOCK_HZ / 1000) * `LAMP_TEST_MS,
  parameter FLASH_ON_CYCLES  = (`CLOCK_HZ / 1000) * `FLASH_ON_MS,
  parameter FLASH_OFF_CYCLES = (`CLOCK_HZ / 1000) * `FLASH_OFF_MS,
  parameter GROUP_GAP_CYCLES = (`CLOCK_HZ / 1000) * `GROUP_GAP_MS
) (
  // clock and reset
  input  wire       CLOCK,
  input  wire       RST,
  // step engine handshake
  output reg        STEP_START,
  output reg  [2:0] STEP_NUM,
  input  wire       STEP_DONE,
  input  wire       STEP_PASS,
  // watchdog request on step one failure
  output reg        REBOOT_REQ,
  // status lamps and summary
  output reg        LED_RED,
  output reg        LED_GREEN,
  output reg        BOOT_OK,
  output reg        BOOT_HALTED
);

  // sequencer states
  // lamp: both lamps lit once after reset
  // run: one cycle to issue the next start pulse
  // wait: a step is in flight, its answer is awaited
  // green: single pass flash of steps two to five
  // fail: red flash groups, repeated until reset
  // done: every step passed, both lamps steady
  // boot: step one failed, the watchdog is asked to reboot
  // no state leads back out of fail, done or boot; only a reset does
  localparam [2:0] S_LAMP  = 3'h0;
  localparam [2:0] S_RUN   = 3'h1;
  localparam [2:0] S_WAIT  = 3'h2;
  localparam [2:0] S_GREEN = 3'h3;
  localparam [2:0] S_FAIL  = 3'h4;
  localparam [2:0] S_DONE  = 3'h5;
  localparam [2:0] S_BOOT  = 3'h6;

  reg [2:0]  state_reg;
  reg [2:0]  state_next;
  reg [31:0] timer_reg;
  reg [31:0] timer_next;
  reg [2:0]  step_reg;
  reg [2:0]  step_next;
  reg [2:0]  count_reg;
  reg [2:0]  count_next;
  reg        phase_reg;
  reg        phase_next;
  reg        red_next;
  reg        green_next;
  reg        start_next;
  reg        pending_reg;
  reg        pending_next;
  wire       lamp_end;
  wire       on_end;
  wire       off_end;
  wire       gap_end;
  wire       group_end;
  wire       group_red;
  wire       result_valid;

  // red flashes in the failure group of a step
  // step one never gets here: its failure asks for a reboot instead
  function [2:0] fail_flashes;
    input [2:0] step;
    begin
      if (step >= `STEP_CONFIG && step <= `STEP_RAM_TEST) begin
        fail_flashes = step - 3'h1;
      end else begin
        fail_flashes = 3'h0;
      end
    end
  endfunction

  // the final step hands over to the all-passed display
  function is_last_step;
    input [2:0] step;
    begin
      is_last_step = (step == `STEP_RAM_TEST);
    end
  endfunction

  // timer end points; the timer restarts at zero for every interval
  // lamp test ends one count later so both lamps stay lit for the full
  // interval and go dark at the same edge as the first start pulse leaves
  assign lamp_end  = (timer_reg >= LAMP_TEST_CYCLES);
  assign on_end    = (timer_reg >= FLASH_ON_CYCLES - 1);
  assign off_end   = (timer_reg >= FLASH_OFF_CYCLES - 1);
  assign gap_end   = (timer_reg >= GROUP_GAP_CYCLES - 1);

  // group bookkeeping; the flash count is decoded from the failed step
  assign group_end = (count_reg == fail_flashes(step_reg));
  assign group_red = (count_reg < fail_flashes(step_reg));

  // a result counts only while a step is in flight; strays are dropped
  assign result_valid = STEP_DONE && pending_reg;

  // in-flight flag: set with the start pulse, cleared by the result
  always @* begin
    pending_next = pending_reg;
    if (start_next) begin
      pending_next = 1'b1;
    end else if (result_valid) begin
      pending_next = 1'b0;
    end
  end

  // sequencer: one timer serves lamp test, flashes and group gaps
  always @* begin
    state_next = state_reg;
    timer_next = timer_reg;
    step_next  = step_reg;
    count_next = count_reg;
    phase_next = phase_reg;
    red_next   = 1'b0;
    green_next = 1'b0;
    start_next = 1'b0;
    case (state_reg)
      S_LAMP: begin
        red_next   = 1'b1;
        green_next = 1'b1;
        if (lamp_end) begin
          // lamps go dark together with the first start pulse
          red_next   = 1'b0;
          green_next = 1'b0;
          timer_next = 32'h0;
          step_next  = `STEP_SETUP;
          start_next = 1'b1;
          state_next = S_WAIT;
        end else begin
          timer_next = timer_reg + 32'h1;
        end
      end
      S_RUN: begin
        // issue next step once the previous flash ended, or right after step one passed
        start_next = 1'b1;
        state_next = S_WAIT;
        // green stays lit while step two runs after step one passed
        green_next = (step_reg == `STEP_CONFIG);
      end
      S_WAIT: begin
        // step one result holds green steady until step two answers
        green_next = (step_reg == `STEP_CONFIG);
        if (result_valid) begin
          if (!STEP_PASS && step_reg == `STEP_SETUP) begin
            state_next = S_BOOT;
          end else if (!STEP_PASS) begin
            // failure code count equals step number minus one
            // a halt shows red only, so the steady green goes dark
            green_next = 1'b0;
            count_next = 3'h0;
            phase_next = 1'b1;
            timer_next = 32'h0;
            state_next = S_FAIL;
          end else if (step_reg == `STEP_SETUP) begin
            green_next = 1'b1;
            step_next  = `STEP_CONFIG;
            state_next = S_RUN;
          end else begin
            timer_next = 32'h0;
            phase_next = 1'b1;
            state_next = S_GREEN;
          end
        end
      end
      S_GREEN: begin
        // single green flash: on then off, red held dark
        green_next = phase_reg;
        if (phase_reg && on_end) begin
          phase_next = 1'b0;
          timer_next = 32'h0;
          green_next = 1'b0;
        end else if (!phase_reg && off_end) begin
          timer_next = 32'h0;
          if (is_last_step(step_reg)) begin
            // lamps come on in the same cycle as the pass summary
            red_next   = 1'b1;
            green_next = 1'b1;
            state_next = S_DONE;
          end else begin
            step_next  = step_reg + 3'h1;
            state_next = S_RUN;
          end
        end else begin
          timer_next = timer_reg + 32'h1;
        end
      end
      S_FAIL: begin
        // repeat groups of step-1 red flashes, green dark, forever
        red_next = phase_reg && group_red;
        if (group_end) begin
          // dark gap marks the end of a group
          if (gap_end) begin
            timer_next = 32'h0;
            count_next = 3'h0;
            phase_next = 1'b1;
          end else begin
            timer_next = timer_reg + 32'h1;
          end
        end else if (phase_reg && on_end) begin
          timer_next = 32'h0;
          phase_next = 1'b0;
        end else if (!phase_reg && off_end) begin
          timer_next = 32'h0;
          phase_next = 1'b1;
          count_next = count_reg + 3'h1;
        end else begin
          timer_next = timer_reg + 32'h1;
        end
      end
      S_DONE: begin
        red_next   = 1'b1;
        green_next = 1'b1;
      end
      S_BOOT: begin
        // wait for the watchdog reset; lamps dark
        state_next = S_BOOT;
      end
      default: begin
        state_next = S_LAMP;
      end
    endcase
  end

  // state registers; one shared timer, so only one interval runs at a time
  always @(posedge CLOCK) begin
    if (RST) begin
      state_reg   <= S_LAMP;
      timer_reg   <= 32'h0;
      step_reg    <= 3'h0;
      count_reg   <= 3'h0;
      phase_reg   <= 1'b0;
      pending_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      timer_reg   <= timer_next;
      step_reg    <= step_next;
      count_reg   <= count_next;
      phase_reg   <= phase_next;
      pending_reg <= pending_next;
    end
  end

  // handshake outputs, registered so the step engine sees clean levels
  always @(posedge CLOCK) begin
    if (RST) begin
      STEP_START <= 1'b0;
      STEP_NUM   <= 3'h0;
    end else begin
      STEP_START <= start_next;
      STEP_NUM   <= step_next;
    end
  end

  // lamps, straight from flip-flops to avoid glitches on the pins
  always @(posedge CLOCK) begin
    if (RST) begin
      LED_RED   <= 1'b0;
      LED_GREEN <= 1'b0;
    end else begin
      LED_RED   <= red_next;
      LED_GREEN <= green_next;
    end
  end

  // sticky summaries; only a reset clears them
  always @(posedge CLOCK) begin
    if (RST) begin
      REBOOT_REQ  <= 1'b0;
      BOOT_OK     <= 1'b0;
      BOOT_HALTED <= 1'b0;
    end else begin
      REBOOT_REQ  <= (state_next == S_BOOT);
      BOOT_OK     <= (state_next == S_DONE);
      BOOT_HALTED <= (state_next == S_FAIL);
    end
  end

endmodule

/* File: src/boot_seq_consts.vh */
// Overview of operation
// - both lamps lit one second first
// - flashing lamp keeps the other dark
// - all passed: both lamps steady on
// - step one pass green steady; fail reboots
// - step two fail: one red flash repeating
// - step three fail: two red flashes repeating
// - step four fail: three red flashes repeating
// - step five fail: four red flashes repeating
// - step one sets up processor memory access
// - step two loads logic array configuration
// - step three compares identity with name
// - step four compares computed and stored checksum
// - step five writes, reads back RAM patterns
// - steps strictly ordered; failure stops boot
`ifndef BOOT_SEQ_CONSTS_VH
`define BOOT_SEQ_CONSTS_VH
`define CLOCK_HZ        50000000
`define LAMP_TEST_MS    1000
`define FLASH_ON_MS     250
`define FLASH_OFF_MS    250
`define GROUP_GAP_MS    1000
`define STEP_COUNT      5
// step numbers, one-based
`define STEP_SETUP      3'h1
`define STEP_CONFIG     3'h2
`define STEP_SIGNATURE  3'h3
`define STEP_CHECKSUM   3'h4
`define STEP_RAM_TEST   3'h5
`endif

/* File: verif/boot_seq_checker.sv */
`timescale 1ns/1ps
module boot_seq_checker (
  // design ports, watched only
  input wire       CLOCK, RST, STEP_START, STEP_DONE, STEP_PASS,
  input wire [2:0] STEP_NUM,
  input wire       REBOOT_REQ, LED_RED, LED_GREEN, BOOT_OK, BOOT_HALTED
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // lamp test, one lamp at a time, final lamps
  property p_lamp; $fell(RST) |-> ##1 (LED_RED && LED_GREEN) [*8]; endproperty
  a_lamp: assert property (p_lamp) else $error("lamp test");
  property p_one; (BOOT_HALTED || STEP_NUM inside {[1:4]}) |-> !(LED_RED && LED_GREEN); endproperty
  a_one: assert property (p_one) else $error("both lit");
  property p_all; BOOT_OK |-> LED_RED && LED_GREEN && STEP_NUM == 3'h5; endproperty
  a_all: assert property (p_all) else $error("final lamps");
  property p_reb; REBOOT_REQ |-> STEP_NUM == 3'h1 && !BOOT_HALTED && !BOOT_OK; endproperty
  a_reb: assert property (p_reb) else $error("reboot");
  // halt must show red and start nothing further
  property p_red; $rose(BOOT_HALTED) |-> ##[0:12] LED_RED; endproperty
  a_red: assert property (p_red) else $error("no red");
  property p_stop; BOOT_HALTED |-> !LED_GREEN && !STEP_START; endproperty
  a_stop: assert property (p_stop) else $error("halt");
  property p_ord; $changed(STEP_NUM) |-> STEP_NUM == $past(STEP_NUM) + 3'h1; endproperty
  a_ord: assert property (p_ord) else $error("order");
  property p_pulse; STEP_START |=> !STEP_START; endproperty
  a_pulse: assert property (p_pulse) else $error("start");
endmodule
bind boot_self_test_led_sequencer boot_seq_checker i_boot_seq_checker (.*);

/* File: verif/step_model.sv */
`timescale 1ns/1ps
module step_model (
  // sequencer side, failing step (0 none) and answer delay
  input wire        CLOCK, RST, STEP_START,
  input wire [2:0]  STEP_NUM, fail_step, lag,
  output logic      STEP_DONE, STEP_PASS
);
  int cnt = -1;
  // answer lag+1 cycles after a start is sampled; verdict line toggles while idle
  always @(posedge CLOCK) begin
    STEP_DONE <= 1'b0;
    STEP_PASS <= ~STEP_PASS;
    if (RST) begin
      cnt <= -1;
      STEP_PASS <= 1'b0;
    end
    else if (STEP_START) cnt <= lag;
    else if (cnt > 0) cnt <= cnt - 1;
    else if (cnt == 0) begin
      STEP_DONE <= 1'b1;
      STEP_PASS <= STEP_NUM != fail_step;
      cnt <= -1;
    end
  end
endmodule

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
  // bench drives, partner answers, design outputs
  logic       CLOCK = 1'b0, RST = 1'b1, stray = 1'b0, dm, pm, STEP_START, REBOOT_REQ;
  logic       LED_RED, LED_GREEN, BOOT_OK, BOOT_HALTED;
  logic [2:0] STEP_NUM, n, fail_step = 3'h0;
  // per failing step: ok, reboot, halted, red flashes per group
  logic [5:0] rows [6] = '{6'h20, 6'h10, 6'h09, 6'h0a, 6'h0b, 6'h0c};
  int         num_errors = 0, compares = 0, cyc = 0, d;
  // stray failing strobe, to be ignored outside a step
  wire        STEP_DONE = dm | stray;
  wire        STEP_PASS = pm & ~stray;
  boot_self_test_led_sequencer #(20, 4, 4, 8) i_boot_self_test_led_sequencer (.*);
  step_model i_step_model (.*, .lag(fail_step), .STEP_DONE(dm), .STEP_PASS(pm));
  initial forever #10 CLOCK = ~CLOCK;
  // hang guard, far above the longest run
  always @(posedge CLOCK) if (++cyc == 5000) close_out(1);
  task automatic close_out(input int bump);
    num_errors += bump;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [2:0] e, input logic [2:0] g);
    compares++;
    if (e !== g) begin
      num_errors++;
      $display("unexpected %s exp %0h got %0h", s, e, g);
    end
  endtask
  // a long dark run marks the gap between red groups
  task automatic group;
    d = 0;
    while (d < 6) begin
      @(negedge CLOCK);
      d = LED_RED ? 0 : d + 1;
    end
    n = 3'h0;
    while (d < 6 || n == 3'h0) begin
      @(negedge CLOCK);
      n += LED_RED && d > 0;
      d = LED_RED ? 0 : d + 1;
    end
  endtask
  initial begin
    for (int r = 0; r < 6; r++) begin
      fail_step = r[2:0];
      RST = 1'b1;
      repeat (8) @(negedge CLOCK);
      RST = 1'b0;
      repeat (4) @(negedge CLOCK);
      stray = 1'b1;
      @(negedge CLOCK);
      stray = 1'b0;
      while (!(BOOT_OK | REBOOT_REQ | BOOT_HALTED)) @(negedge CLOCK);
      chk("outcome", rows[r][5:3], {BOOT_OK, REBOOT_REQ, BOOT_HALTED});
      if (BOOT_OK) chk("lamps", 3'h3, {1'b0, LED_RED, LED_GREEN});
      if (BOOT_HALTED) begin
        group;
        chk("red group", rows[r][2:0], n);
      end
    end
    // reset in the dark gap between red groups must darken everything
    RST = 1'b1;
    repeat (2) @(negedge CLOCK);
    chk("reset", 3'h0, {LED_RED, LED_GREEN, BOOT_HALTED});
    // seventh release: lamp test lights both lamps at the first edge
    RST = 1'b0;
    @(negedge CLOCK);
    chk("lamp test", 3'h3, {1'b0, LED_RED, LED_GREEN});
    close_out(0);
  end
endmodule
